// ===== lpi_device.sv
// Device-side pin logic: clock edge detection, capture, masking, strobes
// Contract
// - Capture CA on both clock edges
// - Sample select and enable on rising edge
// - Rising edge is true-high, complement-low crossing
// - Enable low disables buffers and drivers
// - Power mode changes only on enable transitions
// - Command decoded from enable, select, CA together
// - Drop write beat when mask high
// - Sample mask on both strobe edges
// - Mask 2,3 guard lanes 16-23, 24-31
// - Strobe driven by device with read data
// - Read strobe edge-aligned with read data
// - Strobe n serves byte lane n
// - Termination follows control input and mode value
// - Data lines bidirectional, shared read/write
`timescale 1ns/100ps
module lpi_device (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Command and clock pins
  input wire logic ck_t,
  input wire logic ck_c,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [9:0] ca,
  // Data mask and strobe pins
  input wire logic [3:0] dm,
  input wire logic [3:0] dqs_t_in,
  input wire logic [3:0] dqs_c_in,
  output logic [3:0] dqs_t_out,
  output logic [3:0] dqs_c_out,
  output logic [3:0] dqs_oe,
  // Data pins
  input wire logic [31:0] dq_in,
  output logic [31:0] dq_out,
  output logic [31:0] dq_oe,
  // Termination control
  input wire logic odt,
  input wire logic odt_mode_en,
  output logic term_on,
  // User side: commands and write data out
  output lpi_pkg::lpi_cmd_t cmd,
  output logic cmd_valid,
  output lpi_pkg::lpi_beat_t wr_beat,
  output logic [3:0] wr_valid,
  // User side: read data in
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  // Power state
  output logic powered
);

  // ----------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------
  logic [1:0] ck_s;
  logic [11:0] ctl_s;
  logic [3:0] dm_s, st_s, sc_s;
  logic [31:0] dq_s;
  logic ck_t_d, ck_c_d;
  logic [3:0] st_d, sc_d;
  logic rise, fall;
  logic [3:0] s_rise, s_fall;
  logic [9:0] ca_r_reg;
  logic cke_d_reg;
  logic cke_p_reg;
  logic active;
  logic odt_s;
  lpi_pkg::lpi_pwr_t pwr_reg;
  logic rd_ph_reg;
  lpi_pkg::lpi_beat_t beat_next;

  lpi_sync #(.W(2)) u_ck (.ref_clk(ref_clk), .reset(reset),
    .d({ck_t, ck_c}), .q(ck_s));
  lpi_sync #(.W(12)) u_ctl (.ref_clk(ref_clk), .reset(reset),
    .d({cke, cs_n, ca}), .q(ctl_s));
  lpi_sync #(.W(13)) u_dm (.ref_clk(ref_clk), .reset(reset),
    .d({odt, dm, dqs_t_in, dqs_c_in}), .q({odt_s, dm_s, st_s, sc_s}));
  lpi_sync #(.W(32)) u_dq (.ref_clk(ref_clk), .reset(reset),
    .d(dq_in), .q(dq_s));

  // ----------------------------------------------------------------
  // Edge detection on differential pairs
  // ----------------------------------------------------------------
  // Crossing detected when the pair swaps sense from last sample
  function automatic logic cross_up(input logic t, input logic c,
                                    input logic tp, input logic cp);
    cross_up = t && !c && !tp && cp;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ck_t_d <= 1'b0;
      ck_c_d <= 1'b1;
      st_d <= lpi_pkg::LANE_RST;
      sc_d <= 4'hF;
    end else begin
      ck_t_d <= ck_s[1];
      ck_c_d <= ck_s[0];
      st_d <= st_s;
      sc_d <= sc_s;
    end
  end

  assign rise = cross_up(ck_s[1], ck_s[0], ck_t_d, ck_c_d);
  assign fall = cross_up(ck_s[0], ck_s[1], ck_c_d, ck_t_d);
  always_comb begin
    for (int i = 0; i < lpi_pkg::LANES; i++) begin
      s_rise[i] = cross_up(st_s[i], sc_s[i], st_d[i], sc_d[i]);
      s_fall[i] = cross_up(sc_s[i], st_s[i], sc_d[i], st_d[i]);
    end
  end

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  // Rising half of CA held until the falling half completes the word
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ca_r_reg <= lpi_pkg::CA_RST;
      // Enable counts as high out of reset, matching the active state
      cke_d_reg <= 1'b1;
      cke_p_reg <= 1'b1;
      cmd <= '0;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (rise) begin
        ca_r_reg <= ctl_s[9:0];
        cmd.cke <= ctl_s[11];
        cmd.cs_n <= ctl_s[10];
        cke_d_reg <= ctl_s[11];
        cke_p_reg <= cke_d_reg;
      end
      if (fall) begin
        cmd.ca_rise <= ca_r_reg;
        cmd.ca_fall <= ctl_s[9:0];
        // Whole word presented together; deselect carries nothing
        cmd_valid <= !cmd.cs_n && (cmd.cke || cke_p_reg);
      end
    end
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Changes only on a sampled enable transition, not on level alone
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pwr_reg <= lpi_pkg::LPI_ACTIVE;
    end else if (rise && (ctl_s[11] != cke_d_reg)) begin
      unique case (pwr_reg)
        lpi_pkg::LPI_ACTIVE: pwr_reg <= lpi_pkg::LPI_PWRDN;
        lpi_pkg::LPI_PWRDN: pwr_reg <= lpi_pkg::LPI_ACTIVE;
      endcase
    end
  end
  assign active = (pwr_reg == lpi_pkg::LPI_ACTIVE);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      powered <= 1'b1;
    end else begin
      powered <= active;
    end
  end

  // ----------------------------------------------------------------
  // Write capture with byte masks
  // ----------------------------------------------------------------
  // Lane n takes dq[8n+7:8n] on either edge of strobe n, masked by dm[n]
  always_comb begin
    beat_next = wr_beat;
    for (int i = 0; i < lpi_pkg::LANES; i++) begin
      if (s_rise[i] || s_fall[i]) begin
        beat_next.data[i*8 +: 8] = dq_s[i*8 +: 8];
        beat_next.lane_en[i] = !dm_s[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_beat <= '0;
      wr_valid <= lpi_pkg::LANE_RST;
    end else begin
      wr_beat <= beat_next;
      // Masked lanes raise no valid, so the beat is discarded
      wr_valid <= (s_rise | s_fall) & ~dm_s
                  & {lpi_pkg::LANES{active && !rd_ph_reg}};
    end
  end

  // ----------------------------------------------------------------
  // Read drive: data and strobe change on the same edge
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_ph_reg <= 1'b0;
      dq_out <= lpi_pkg::DQ_RST;
      dq_oe <= lpi_pkg::DQ_RST;
      dqs_t_out <= lpi_pkg::LANE_RST;
      dqs_c_out <= 4'hF;
      dqs_oe <= lpi_pkg::LANE_RST;
    end else begin
      rd_ph_reg <= rd_en && active;
      dq_oe <= {lpi_pkg::DQ_W{rd_en && active}};
      dqs_oe <= {lpi_pkg::LANES{rd_en && active}};
      if (rd_en && active) begin
        dq_out <= rd_data;
        // Strobe toggles with each new word: edge aligned
        dqs_t_out <= ~dqs_t_out;
        dqs_c_out <= dqs_t_out;
      end else begin
        dqs_t_out <= lpi_pkg::LANE_RST;
        dqs_c_out <= 4'hF;
      end
    end
  end

  // ----------------------------------------------------------------
  // Termination: off while driving reads or powered down
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      term_on <= 1'b0;
    end else begin
      term_on <= odt_s && odt_mode_en && active && !rd_en;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cmd_sel;
    @(posedge ref_clk) disable iff (reset)
      cmd_valid |-> !cmd.cs_n;
  endproperty
  a_cmd_sel: assert property (p_cmd_sel) else $error("cmd while deselected");

  property p_cmd_fall;
    @(posedge ref_clk) disable iff (reset)
      cmd_valid |-> $past(fall);
  endproperty
  a_cmd_fall: assert property (p_cmd_fall) else $error("cmd not on fall");

  property p_ca_rise;
    @(posedge ref_clk) disable iff (reset)
      rise |=> ca_r_reg == $past(ctl_s[9:0]);
  endproperty
  a_ca_rise: assert property (p_ca_rise) else $error("CA rise missed");

  property p_cs_hold;
    @(posedge ref_clk) disable iff (reset)
      !rise |=> $stable(cmd.cs_n) && $stable(cmd.cke);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("SDR sampled off edge");

  property p_mask;
    @(posedge ref_clk) disable iff (reset)
      ((s_rise[2] || s_fall[2]) && dm_s[2]) |=> !wr_valid[2];
  endproperty
  a_mask: assert property (p_mask) else $error("masked beat kept");

  property p_pwr;
    @(posedge ref_clk) disable iff (reset)
      $changed(pwr_reg) |-> $past(rise) && $past(ctl_s[11] != cke_d_reg);
  endproperty
  a_pwr: assert property (p_pwr) else $error("mode change w/o CKE edge");

  property p_off;
    @(posedge ref_clk) disable iff (reset)
      !active |=> dq_oe == '0 && dqs_oe == '0 && !term_on;
  endproperty
  a_off: assert property (p_off) else $error("driver on while down");

  property p_align;
    @(posedge ref_clk) disable iff (reset)
      (dqs_oe[0] && $past(dqs_oe[0])) |-> $changed(dqs_t_out[0]);
  endproperty
  a_align: assert property (p_align) else $error("strobe not edge aligned");

  property p_odt;
    @(posedge ref_clk) disable iff (reset)
      term_on |-> $past(odt_s) && $past(odt_mode_en);
  endproperty
  a_odt: assert property (p_odt) else $error("termination w/o ODT");

endmodule

// ===== lpi_device_tb.sv
// Self-checking testbench for the device pin interface
`timescale 1ns/100ps
module lpi_device_tb;
  logic ref_clk, reset, ck_t, ck_c, cke, cs_n, odt, odt_mode_en;
  logic rd_en, cmd_valid, term_on, powered;
  logic [9:0] ca;
  logic [3:0] dm, dqs_h, dqs_t_out, dqs_c_out, dqs_oe, wr_valid;
  logic [3:0] dqs_t_w, dqs_c_w;
  logic [31:0] dq_h, dq_out, dq_oe, dq_w, rd_data;
  lpi_pkg::lpi_cmd_t cmd;
  lpi_pkg::lpi_beat_t wr_beat;
  int fail_count = 0;
  int samples_checked = 0;

  // Wire levels: device drives where its enables are set, host everywhere else
  assign dq_w = (dq_oe & dq_out) | (~dq_oe & dq_h);
  assign dqs_t_w = (dqs_oe & dqs_t_out) | (~dqs_oe & dqs_h);
  assign dqs_c_w = (dqs_oe & dqs_c_out) | (~dqs_oe & ~dqs_h);

  lpi_host lpi_host_i (.ref_clk(ref_clk), .ck_t(ck_t), .ck_c(ck_c),
    .cke(cke), .cs_n(cs_n), .ca(ca), .dm(dm), .dqs_h(dqs_h), .dq_h(dq_h));

  lpi_device lpi_device_i (.ref_clk(ref_clk), .reset(reset), .ck_t(ck_t),
    .ck_c(ck_c), .cke(cke), .cs_n(cs_n), .ca(ca), .dm(dm),
    .dqs_t_in(dqs_t_w), .dqs_c_in(dqs_c_w), .dqs_t_out(dqs_t_out),
    .dqs_c_out(dqs_c_out), .dqs_oe(dqs_oe), .dq_in(dq_w),
    .dq_out(dq_out), .dq_oe(dq_oe), .odt(odt), .odt_mode_en(odt_mode_en),
    .term_on(term_on), .cmd(cmd), .cmd_valid(cmd_valid),
    .wr_beat(wr_beat), .wr_valid(wr_valid), .rd_en(rd_en),
    .rd_data(rd_data), .powered(powered));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Bounded wait for a write pulse (w=1) or a command pulse (w=0)
  task automatic wait_flag(input logic w, output logic got);
    got = 1'b0;
    for (int i = 0; i < 16 && !got; i++) begin
      @(posedge ref_clk);
      #1;
      got = w ? (wr_valid !== 4'h0) : (cmd_valid === 1'b1);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_cmd(input logic k, input logic s, input logic [9:0] r,
                       input logic [9:0] f, input logic ok, input logic pw);
    logic got;
    fork
      lpi_host_i.send_cmd(k, s, r, f);
      wait_flag(1'b0, got);
    join
    check("cmd_valid", 32'(got), 32'(ok));
    if (ok) begin
      check("cmd", 32'(cmd), 32'({k, s, r, f}));
    end
    check("powered", 32'(powered), 32'(pw));
  endtask

  task automatic t_write(input logic [31:0] d, input logic [3:0] m,
                         input logic [3:0] sel);
    logic got;
    logic [3:0] v;
    logic [31:0] bm;
    v = sel & ~m;
    bm = {{8{v[3]}}, {8{v[2]}}, {8{v[1]}}, {8{v[0]}}};
    fork
      lpi_host_i.beat(d, m, sel);
      wait_flag(1'b1, got);
    join
    check("wr_valid", 32'(wr_valid), 32'(v));
    // Unstrobed lanes keep their previous enable, so only strobed ones
    check("lane_en", 32'(wr_beat.lane_en & sel), 32'(v));
    check("wr_data", wr_beat.data & bm, d & bm);
  endtask

  task automatic t_read();
    logic [3:0] s;
    rd_en = 1'b1;
    rd_data = 32'h89AB_CDEF;
    @(posedge ref_clk);
    #1;
    s = dqs_t_out;
    check("dq_out", dq_out, 32'h89AB_CDEF);
    check("dq_oe", dq_oe, 32'hFFFF_FFFF);
    check("dqs_oe", 32'(dqs_oe), 32'h0000_000F);
    check("term_on", 32'(term_on), 32'h0);
    rd_data = 32'h7654_3210;
    @(posedge ref_clk);
    #1;
    check("dq_out", dq_out, 32'h7654_3210);
    check("dqs_t_out", 32'(dqs_t_out), {28'h0, ~s});
    check("dqs_c_out", 32'(dqs_c_out), 32'(s));
    rd_en = 1'b0;
    @(posedge ref_clk);
    #1;
    check("dq_oe", dq_oe, 32'h0);
    check("dqs_oe", 32'(dqs_oe), 32'h0);
  endtask

  task automatic t_term(input logic o, input logic e, input logic exp);
    odt = o;
    odt_mode_en = e;
    repeat (6) @(posedge ref_clk);
    #1;
    check("term_on", 32'(term_on), 32'(exp));
  endtask

  // Clock, watchdog and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    fail_count++;
    final_report();
  end

  initial begin
    reset = 1'b1;
    rd_en = 1'b0;
    rd_data = 32'h0;
    odt = 1'b0;
    odt_mode_en = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check("powered", 32'(powered), 32'h1);
    check("dqs_c_out", 32'(dqs_c_out), 32'h0000_000F);
    t_cmd(1'b1, 1'b0, 10'h2A5, 10'h15A, 1'b1, 1'b1);
    t_cmd(1'b1, 1'b1, 10'h3C3, 10'h03C, 1'b0, 1'b1);
    t_write(32'h1122_3344, 4'h0, 4'hF);
    t_write(32'hA5A5_5A5A, 4'h5, 4'hF);
    t_write(32'h9C8B_7A69, 4'hA, 4'hF);
    t_write(32'h0F1E_2D3C, 4'h0, 4'h4);
    lpi_host_i.release_bus();
    t_read();
    t_term(1'b1, 1'b1, 1'b1);
    t_term(1'b1, 1'b0, 1'b0);
    t_term(1'b0, 1'b1, 1'b0);
    t_cmd(1'b0, 1'b0, 10'h001, 10'h3FE, 1'b1, 1'b0);
    t_cmd(1'b0, 1'b0, 10'h200, 10'h1FF, 1'b0, 1'b0);
    rd_en = 1'b1;
    @(posedge ref_clk);
    #1;
    check("dq_oe", dq_oe, 32'h0);
    rd_en = 1'b0;
    t_cmd(1'b1, 1'b0, 10'h0F0, 10'h30F, 1'b1, 1'b1);
    final_report();
  end
endmodule

// ===== lpi_host.sv
// Host controller model driving the device's clock, command and write pins
`timescale 1ns/100ps
module lpi_host (
  // Clock
  input wire logic ref_clk,
  // Clock and command pins
  output logic ck_t,
  output logic ck_c,
  output logic cke,
  output logic cs_n,
  output logic [9:0] ca,
  // Write side of mask, strobe and data
  output logic [3:0] dm,
  output logic [3:0] dqs_h,
  output logic [31:0] dq_h
);
  // Idle pins; the link clock stands still low between frames
  initial begin
    ck_t = 1'b0;
    ck_c = 1'b1;
    cke = 1'b1;
    cs_n = 1'b1;
    ca = 10'h000;
    dm = 4'h0;
    dqs_h = 4'h0;
    dq_h = 32'h0000_0000;
  end

  // One 160 ns clock period per command; callers start 1 ns past a
  // ref_clk edge, so every pin moves at that same offset
  task automatic send_cmd(input logic k, input logic s,
                          input logic [9:0] cr, input logic [9:0] cf);
    cke = k;
    cs_n = s;
    ca = cr;
    #20;
    ck_t = 1'b1;
    ck_c = 1'b0;
    #60;
    ca = cf;
    #20;
    ck_t = 1'b0;
    ck_c = 1'b1;
    #60;
    // Select returns high; CA shows the inverse, never a stale value
    cs_n = 1'b1;
    ca = ~cf;
  endtask

  // Data a cycle ahead of the strobe edge, so the edge sits mid-eye
  task automatic beat(input logic [31:0] d, input logic [3:0] m,
                      input logic [3:0] sel);
    @(posedge ref_clk);
    #1;
    dq_h = d;
    dm = m;
    @(posedge ref_clk);
    #1;
    dqs_h = dqs_h ^ sel;
  endtask

  // Host drives the inverse of its last data and mask
  task automatic release_bus();
    dq_h = ~dq_h;
    dm = ~dm;
  endtask
endmodule

// ===== lpi_pkg.sv
// Shared types and constants for the low-power DRAM pin interface
package lpi_pkg;

  // ----------------------------------------------------------------
  // Widths and lane layout
  // ----------------------------------------------------------------
  localparam int CA_W = 10;
  localparam int DQ_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [9:0] CA_RST = 10'h000;
  localparam logic [31:0] DQ_RST = 32'h0000_0000;
  localparam logic [3:0] LANE_RST = 4'h0;
  localparam int SYNC_STAGES = 2;
  localparam int RD_PIPE = 1;

  // Command word, captured as one unit per clock period
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic [9:0] ca_rise;
    logic [9:0] ca_fall;
  } lpi_cmd_t;

  // One write beat after masking
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] lane_en;
  } lpi_beat_t;

  // Power state of the input/output front end
  typedef enum logic [1:0] {
    LPI_ACTIVE = 2'b01,
    LPI_PWRDN = 2'b10
  } lpi_pwr_t;

endpackage

// ===== lpi_sync.sv
// Two-stage synchroniser for a bus of asynchronous pin levels
`timescale 1ns/100ps
module lpi_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Asynchronous input and synchronised output
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage is read only by the second stage
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule
